// ===== design/imv_params.svh
`ifndef IMV_PARAMS_SVH
`define IMV_PARAMS_SVH

// register indices; byte address is four times the index
`define IMV_IDX_GEN 8'hE0
`define IMV_IDX_TU 8'hE1
`define IMV_IDX_VEC 8'hE2
`define IMV_IDX_STAT 8'hE4
`define IMV_IDX_CLR 8'hE5
`define IMV_IDX_EN 8'hE6
`define IMV_WORD(idx) {22'h000000, (idx)}

`define IMV_MASK_RST 8'h00
`define IMV_VEC_RST 8'h00
`define IMV_STAT_RST 3'h0
`define IMV_RDATA_RST 32'h00000000

// vector of source n is (n + 1) times the step; 0 means none pending
`define IMV_VEC_STEP 8'h04
`define IMV_NSRC 15
`define IMV_NEV 3

// source positions in the combined posted vector
`define IMV_SRC_POR 0
`define IMV_SRC_SPI_RX 3
`define IMV_SRC_GPIO1 7
`define IMV_SRC_TICK 13
`define IMV_SRC_INTERVAL 14

// status event positions
`define IMV_EV_NEW_PEND 0
`define IMV_EV_MASKED_POST 1
`define IMV_EV_VEC_CLEAR 2

`endif

// ===== design/imv_pkg.sv
package imv_pkg;

    typedef enum logic [2:0] {
        IMV_R_NONE,
        IMV_R_GEN,
        IMV_R_TU,
        IMV_R_VEC,
        IMV_R_STAT,
        IMV_R_CLR,
        IMV_R_EN
    } imv_reg_t;

    typedef enum logic {
        IMV_BUS_IDLE,
        IMV_BUS_WAIT
    } imv_bus_t;

endpackage

// ===== design/imv_top.sv
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "imv_params.svh"

// How it works
// - timer-usb bit 6 gates interval timer
// - timer-usb bit 5 gates millisecond tick
// - timer-usb bits 4..0 gate usb sources
// - general bit 7 gates second gpio port
// - general bits 6..4 gate sleep, pin1, gpio0
// - general bits 3..2 gate spi receive, transmit
// - general bits 1..0 gate pin0, power-on
// - vector read returns highest-priority pending vector
// - any vector write clears all pending except sources posting in that cycle
// - cleared mask bit keeps interrupt from pending
// - masked sources still record posted interrupts
module imv_top (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire logic ce, // clock enable, freezes state
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write not read
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic por_irq, // power-on event
    input wire logic external_pin0_irq, // pin 0 event
    input wire logic spi_tx_irq, // spi transmit event
    input wire logic spi_rx_irq, // spi receive event
    input wire logic gpio0_irq, // first gpio port event
    input wire logic external_pin1_irq, // pin 1 event
    input wire logic sleep_timer_irq, // sleep timer event
    input wire logic gpio1_irq, // second gpio port event
    input wire logic endpoint_zero_irq, // usb endpoint 0
    input wire logic endpoint_one_irq, // usb endpoint 1
    input wire logic endpoint_two_irq, // usb endpoint 2
    input wire logic usb_reset_irq, // usb bus reset
    input wire logic usb_active_irq, // usb bus activity
    input wire logic tick_1ms_irq, // millisecond tick
    input wire logic interval_timer_irq, // interval timer
    output logic irq_request, // some interrupt pending
    output logic [7:0] irq_vector, // registered vector
    output logic irq_out // enabled status summary
);

    imv_pkg::imv_bus_t state_ff;
    imv_pkg::imv_reg_t sel_ff;
    logic wr_ff;
    logic [7:0] gen_mask_ff;
    logic [6:0] tu_mask_ff;
    logic [`IMV_NSRC-1:0] posted_ff;
    logic [`IMV_NSRC-1:0] pend_d_ff;
    logic [7:0] vector_ff;
    logic req_ff;
    logic [`IMV_NEV-1:0] stat_ff;
    logic [`IMV_NEV-1:0] en_ff;
    logic irq_ff;
    logic [31:0] hrdata_ff;
    logic hready_ff;

    function automatic imv_pkg::imv_reg_t imv_dec(input logic [31:0] a);
        imv_pkg::imv_reg_t r;
        r = imv_pkg::IMV_R_NONE;
        if (a[31:2] == `IMV_WORD(`IMV_IDX_GEN)) r = imv_pkg::IMV_R_GEN;
        if (a[31:2] == `IMV_WORD(`IMV_IDX_TU)) r = imv_pkg::IMV_R_TU;
        if (a[31:2] == `IMV_WORD(`IMV_IDX_VEC)) r = imv_pkg::IMV_R_VEC;
        if (a[31:2] == `IMV_WORD(`IMV_IDX_STAT)) r = imv_pkg::IMV_R_STAT;
        if (a[31:2] == `IMV_WORD(`IMV_IDX_CLR)) r = imv_pkg::IMV_R_CLR;
        if (a[31:2] == `IMV_WORD(`IMV_IDX_EN)) r = imv_pkg::IMV_R_EN;
        return r;
    endfunction

    // lowest index wins; scanning downward leaves the winner last
    function automatic logic [7:0] imv_encode(input logic [`IMV_NSRC-1:0] p);
        logic [7:0] v;
        v = `IMV_VEC_RST;
        for (int i = `IMV_NSRC - 1; i >= 0; i--) begin
            if (p[i]) v = 8'(i + 1) * `IMV_VEC_STEP;
        end
        return v;
    endfunction

    // bus side
    wire addr_ok_w = hsel && htrans[1] && hready;
    wire data_ph_w = (state_ff == imv_pkg::IMV_BUS_WAIT);
    wire do_wr_w = ce && data_ph_w && wr_ff;
    wire do_rd_w = ce && data_ph_w && !wr_ff;
    wire gen_wr_w = do_wr_w && (sel_ff == imv_pkg::IMV_R_GEN);
    wire tu_wr_w = do_wr_w && (sel_ff == imv_pkg::IMV_R_TU);
    wire vec_clr_w = do_wr_w && (sel_ff == imv_pkg::IMV_R_VEC);
    wire en_wr_w = do_wr_w && (sel_ff == imv_pkg::IMV_R_EN);
    wire clr_wr_w = do_wr_w && (sel_ff == imv_pkg::IMV_R_CLR);
    wire mask_wr_w = gen_wr_w || tu_wr_w;

    // source order follows the mask bit order, general mask low
    wire [`IMV_NSRC-1:0] src_w = {
        interval_timer_irq, tick_1ms_irq, usb_active_irq, usb_reset_irq,
        endpoint_two_irq, endpoint_one_irq, endpoint_zero_irq,
        gpio1_irq, sleep_timer_irq, external_pin1_irq, gpio0_irq,
        spi_rx_irq, spi_tx_irq, external_pin0_irq, por_irq
    };

    wire [`IMV_NSRC-1:0] mask_w = {tu_mask_ff, gen_mask_ff};
    wire [`IMV_NSRC-1:0] pending_w = posted_ff & mask_w;
    wire [7:0] enc_w = imv_encode(pending_w);

    // only the pending ones go; masked posts survive the clear
    wire [`IMV_NSRC-1:0] kill_w = vec_clr_w ? mask_w : {`IMV_NSRC{1'b0}};

    wire [`IMV_NEV-1:0] ev_w;
    assign ev_w[`IMV_EV_NEW_PEND] = |(pending_w & ~pend_d_ff);
    assign ev_w[`IMV_EV_MASKED_POST] = |(src_w & ~mask_w);
    assign ev_w[`IMV_EV_VEC_CLEAR] = vec_clr_w;
    wire [`IMV_NEV-1:0] stat_clr_w = clr_wr_w ? hwdata[`IMV_NEV-1:0] : `IMV_STAT_RST;
    // an event in the clearing cycle stays set
    wire [`IMV_NEV-1:0] nxt_stat = (stat_ff & ~stat_clr_w) | ev_w;
    wire nxt_irq = |(nxt_stat & en_ff);

    wire [31:0] rd_mux_w =
        (sel_ff == imv_pkg::IMV_R_GEN) ? {24'h000000, gen_mask_ff} :
        (sel_ff == imv_pkg::IMV_R_TU) ? {25'h0000000, tu_mask_ff} :
        (sel_ff == imv_pkg::IMV_R_VEC) ? {24'h000000, enc_w} :
        (sel_ff == imv_pkg::IMV_R_STAT) ? {29'h00000000, stat_ff} :
        (sel_ff == imv_pkg::IMV_R_EN) ? {29'h00000000, en_ff} :
        32'h00000000;

    // one wait state per transfer so a read sees any write before it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= imv_pkg::IMV_BUS_IDLE;
            sel_ff <= imv_pkg::IMV_R_NONE;
            wr_ff <= 1'b0;
            hready_ff <= 1'b1;
        end else if (ce) begin
            case (state_ff)
                imv_pkg::IMV_BUS_IDLE: begin
                    if (addr_ok_w) begin
                        state_ff <= imv_pkg::IMV_BUS_WAIT;
                        sel_ff <= imv_dec(haddr);
                        wr_ff <= hwrite;
                        hready_ff <= 1'b0;
                    end
                end
                imv_pkg::IMV_BUS_WAIT: begin
                    state_ff <= imv_pkg::IMV_BUS_IDLE;
                    hready_ff <= 1'b1;
                end
                default: begin
                    state_ff <= imv_pkg::IMV_BUS_IDLE;
                    hready_ff <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= `IMV_RDATA_RST;
        end else if (do_rd_w) begin
            hrdata_ff <= rd_mux_w;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gen_mask_ff <= `IMV_MASK_RST;
            tu_mask_ff <= 7'(`IMV_MASK_RST);
            en_ff <= `IMV_STAT_RST;
        end else begin
            if (gen_wr_w) gen_mask_ff <= hwdata[7:0];
            if (tu_wr_w) tu_mask_ff <= hwdata[6:0];
            if (en_wr_w) en_ff <= hwdata[`IMV_NEV-1:0];
        end
    end

    // one posted flag per source, kept whatever its mask says
    genvar g;
    generate
        for (g = 0; g < `IMV_NSRC; g++) begin : g_post
            wire nxt_posted = (posted_ff[g] && !kill_w[g]) || src_w[g];
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    posted_ff[g] <= 1'b0;
                end else if (ce) begin
                    posted_ff[g] <= nxt_posted;
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vector_ff <= `IMV_VEC_RST;
            req_ff <= 1'b0;
            pend_d_ff <= {`IMV_NSRC{1'b0}};
            stat_ff <= `IMV_STAT_RST;
            irq_ff <= 1'b0;
        end else if (ce) begin
            vector_ff <= enc_w;
            req_ff <= |pending_w;
            pend_d_ff <= pending_w;
            stat_ff <= nxt_stat;
            irq_ff <= nxt_irq;
        end
    end

    assign hreadyout = hready_ff;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign irq_request = req_ff;
    assign irq_vector = vector_ff;
    assign irq_out = irq_ff;

    default clocking imv_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    interval_gate_a: assert property (
        ce && interval_timer_irq && tu_mask_ff[6] && !mask_wr_w
        |=> pending_w[`IMV_SRC_INTERVAL])
        else $error("unmasked interval timer not pending");

    tick_gate_a: assert property (
        ce && !tu_mask_ff[5] && !mask_wr_w |=> !pending_w[`IMV_SRC_TICK])
        else $error("masked tick became pending");

    usb_gate_a: assert property (
        ce && (tu_mask_ff[4:0] == 5'h00) && !mask_wr_w |=> (pending_w[12:8] == 5'h00))
        else $error("masked usb source became pending");

    gpio1_gate_a: assert property (
        ce && gpio1_irq && gen_mask_ff[7] && !mask_wr_w
        |=> pending_w[`IMV_SRC_GPIO1] ##1 (!$past(ce) || (irq_vector != 8'h00)))
        else $error("unmasked second gpio not pending");

    mid_gate_a: assert property (
        ce && (gen_mask_ff[6:4] == 3'h0) && !mask_wr_w |=> (pending_w[6:4] == 3'h0))
        else $error("masked sleep, pin1 or gpio0 pending");

    spi_gate_a: assert property (
        ce && spi_rx_irq && gen_mask_ff[3] && !mask_wr_w |=> pending_w[`IMV_SRC_SPI_RX])
        else $error("unmasked spi receive not pending");

    por_vector_a: assert property (
        ce && por_irq && gen_mask_ff[0] && !mask_wr_w ##1 ce |=> (irq_vector == `IMV_VEC_STEP))
        else $error("power-on vector not presented");

    vec_read_a: assert property (
        do_rd_w && (sel_ff == imv_pkg::IMV_R_VEC) |=> (hrdata == {24'h000000, $past(enc_w)}) && hreadyout)
        else $error("vector read returned wrong value");

    vec_clear_a: assert property (
        vec_clr_w && (src_w == {`IMV_NSRC{1'b0}}) |=> (pending_w == {`IMV_NSRC{1'b0}})
        ##1 (!$past(ce) || !irq_request))
        else $error("vector write left an interrupt pending");

    req_gate_a: assert property (
        ce && (pending_w == {`IMV_NSRC{1'b0}}) |=> !irq_request)
        else $error("request raised with nothing pending");

    masked_hold_a: assert property (
        ce && !vec_clr_w |=> ((posted_ff & $past(posted_ff)) == $past(posted_ff)))
        else $error("posted interrupt lost without clear");

    reset_zero_a: assert property (
        $rose(hresetn) |-> (gen_mask_ff == 8'h00) && (tu_mask_ff == 7'h00) && (irq_vector == 8'h00))
        else $error("masks or vector not zero after reset");

    // passing side: an unmasked pulse is pending one edge later
    tick_pass_a: assert property (
        ce && tick_1ms_irq && tu_mask_ff[5] && !mask_wr_w |=> pending_w[`IMV_SRC_TICK])
        else $error("unmasked tick not pending");

    ep0_pass_a: assert property (
        ce && endpoint_zero_irq && tu_mask_ff[0] && !mask_wr_w |=> pending_w[8])
        else $error("unmasked endpoint 0 not pending");

    usb_rst_pass_a: assert property (
        ce && usb_reset_irq && tu_mask_ff[3] && !mask_wr_w |=> pending_w[11])
        else $error("unmasked usb reset not pending");

    sleep_pass_a: assert property (
        ce && sleep_timer_irq && gen_mask_ff[6] && !mask_wr_w |=> pending_w[6])
        else $error("unmasked sleep timer not pending");

    gpio0_pass_a: assert property (
        ce && gpio0_irq && gen_mask_ff[4] && !mask_wr_w |=> pending_w[4])
        else $error("unmasked first gpio not pending");

    pin0_pass_a: assert property (
        ce && external_pin0_irq && gen_mask_ff[1] && !mask_wr_w |=> pending_w[1])
        else $error("unmasked pin 0 not pending");

    // blocking side: a clear mask bit keeps the source out of the encoder
    interval_block_a: assert property (
        ce && !tu_mask_ff[6] && !mask_wr_w |=> !pending_w[`IMV_SRC_INTERVAL])
        else $error("masked interval timer became pending");

    gpio1_block_a: assert property (
        ce && !gen_mask_ff[7] && !mask_wr_w |=> !pending_w[`IMV_SRC_GPIO1])
        else $error("masked second gpio became pending");

    tx_block_a: assert property (
        ce && !gen_mask_ff[2] && !mask_wr_w |=> !pending_w[2])
        else $error("masked spi transmit became pending");

    vec_none_a: assert property (
        ce && (pending_w == {`IMV_NSRC{1'b0}}) |=> (irq_vector == `IMV_VEC_RST))
        else $error("vector shown with nothing pending");

    // a post in the clearing cycle survives, so only quiet unmasked sources must drop
    vec_wipe_a: assert property (
        vec_clr_w |=> ((posted_ff & $past(mask_w & ~src_w)) == {`IMV_NSRC{1'b0}}))
        else $error("unmasked post survived a vector write");

    masked_keep_a: assert property (
        ce |=> ((posted_ff & $past(posted_ff & ~mask_w)) == $past(posted_ff & ~mask_w)))
        else $error("masked post lost");

    // bus timing: exactly one wait state per transfer
    bus_wait_a: assert property (
        ce && addr_ok_w && !data_ph_w |=> !hreadyout)
        else $error("transfer taken without a wait state");

    bus_done_a: assert property (
        ce && data_ph_w |=> hreadyout)
        else $error("wait state longer than one cycle");

    rdata_hold_a: assert property (
        !do_rd_w |=> $stable(hrdata))
        else $error("read data changed outside a read");

    // clock enable low must freeze every flop, outputs included
    freeze_hold_a: assert property (
        !ce |=> $stable(posted_ff) && $stable(gen_mask_ff) && $stable(tu_mask_ff) && $stable(stat_ff)
        && $stable(irq_vector) && $stable(irq_request) && $stable(irq_out) && $stable(hreadyout))
        else $error("state moved while clock enable was low");

endmodule

// ===== bench/imv_src_model.sv
`timescale 1ns/1ps
// peripheral side: one-cycle event pulses, lines low between events
module imv_src_model (
    input wire logic hclk, // system clock
    output logic [14:0] src // event lines, index order of the sources
);
    initial src = 15'h0000;

    // called right after a rising edge; the design samples the pulse at the next edge
    task automatic post(input logic [14:0] bits);
        src <= bits;
        @(posedge hclk);
        src <= 15'h0000;
    endtask
endmodule

// ===== bench/interrupt_mask_and_vector_tb.sv
`timescale 1ns/1ps
`include "imv_params.svh"
module interrupt_mask_and_vector_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h00000000;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, irq_request, irq_out;
    logic [7:0] irq_vector;
    logic [14:0] src;
    logic [14:0] m;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    localparam logic [31:0] A_GEN = {`IMV_WORD(`IMV_IDX_GEN), 2'b00};
    localparam logic [31:0] A_TU = {`IMV_WORD(`IMV_IDX_TU), 2'b00};
    localparam logic [31:0] A_VEC = {`IMV_WORD(`IMV_IDX_VEC), 2'b00};
    localparam logic [31:0] A_STAT = {`IMV_WORD(`IMV_IDX_STAT), 2'b00};
    localparam logic [31:0] A_CLR = {`IMV_WORD(`IMV_IDX_CLR), 2'b00};
    localparam logic [31:0] A_EN = {`IMV_WORD(`IMV_IDX_EN), 2'b00};
    localparam logic [31:0] A_BAD = 32'h000003FC;

    always #2 hclk = ~hclk;

    imv_src_model src_u (.hclk(hclk), .src(src));

    imv_top dut_u (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .por_irq(src[0]), .external_pin0_irq(src[1]),
        .spi_tx_irq(src[2]), .spi_rx_irq(src[3]), .gpio0_irq(src[4]), .external_pin1_irq(src[5]),
        .sleep_timer_irq(src[6]), .gpio1_irq(src[7]), .endpoint_zero_irq(src[8]),
        .endpoint_one_irq(src[9]), .endpoint_two_irq(src[10]), .usb_reset_irq(src[11]),
        .usb_active_irq(src[12]), .tick_1ms_irq(src[13]), .interval_timer_irq(src[14]),
        .irq_request(irq_request), .irq_vector(irq_vector), .irq_out(irq_out)
    );

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // hang guard: the whole sequence needs well under 2000 cycles
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            $display("Error at %0t: timeout", $time);
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one single transfer; entered right after a rising edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask

    // source n sits on general bit n for n < 8, else on timer-usb bit n - 8
    task automatic setm(input logic [14:0] mv);
        wr(A_GEN, {24'h000000, mv[7:0]});
        wr(A_TU, {25'h0000000, mv[14:8]});
    endtask

    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(A_GEN, 32'h00000000);
        rdchk(A_TU, 32'h00000000);
        rdchk(A_VEC, 32'h00000000);
        chk({31'h0, hresp}, 32'h00000000);
        wr(A_GEN, 32'h000000A5);
        rdchk(A_GEN, 32'h000000A5);
        wr(A_TU, 32'h000000FF);
        rdchk(A_TU, 32'h0000007F);
        // mid-run reset with both masks nonzero
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(A_GEN, 32'h00000000);
        rdchk(A_TU, 32'h00000000);
        wr(A_STAT, 32'h00000007);
        rdchk(A_STAT, 32'h00000000);
        wr(A_BAD, 32'hFFFFFFFF);
        rdchk(A_BAD, 32'h00000000);
        // each source alone: masked post, then unmask, then clear by vector write
        for (int i = 0; i < 15; i++) begin
            m = 15'h7FFF & ~(15'h0001 << i);
            setm(m);
            src_u.post(15'h0001 << i);
            rdchk(A_VEC, 32'h00000000);
            setm(15'h7FFF);
            rdchk(A_VEC, 32'((i + 1) * 4));
            chk({31'h0, irq_request}, 32'h00000001);
            chk({24'h000000, irq_vector}, 32'((i + 1) * 4));
            wr(A_VEC, 32'(i));
            rdchk(A_VEC, 32'h00000000);
        end
        // clock enable low: a pulse in a frozen cycle is not recorded
        ce <= 1'b0;
        src_u.post(15'h0001);
        ce <= 1'b1;
        rdchk(A_VEC, 32'h00000000);
        // every source at once while unmasked: power-on ranks first
        src_u.post(15'h7FFF);
        rdchk(A_VEC, 32'h00000004);
        wr(A_VEC, 32'h00000000);
        rdchk(A_VEC, 32'h00000000);
        chk({31'h0, irq_request}, 32'h00000000);
        // status, enable and clear around the level output
        wr(A_CLR, 32'h00000007);
        rdchk(A_STAT, 32'h00000000);
        setm(15'h0000);
        src_u.post(15'h0008);
        rdchk(A_STAT, 32'h00000002);
        chk({31'h0, irq_out}, 32'h00000000);
        wr(A_EN, 32'h00000002);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq_out}, 32'h00000001);
        wr(A_CLR, 32'h00000002);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq_out}, 32'h00000000);
        rdchk(A_EN, 32'h00000002);
        rdchk(A_CLR, 32'h00000000);
        // spi receive was posted while masked; it outranks the later posts
        src_u.post(15'h4220);
        wr(A_VEC, 32'h00000000);
        setm(15'h7FFF);
        rdchk(A_VEC, 32'h00000010);
        wr(A_VEC, 32'h000000FF);
        rdchk(A_VEC, 32'h00000000);
        end_sim();
    end
endmodule
